// file: core/pin_select_pkg.sv
// Purpose: Shared constants and carriers for the pin-select register block.
// Assumes: 12-bit register addresses, 8-bit register data.
// Notes: Offsets are byte addresses on the plain register port.
package pin_select_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int SEL_W = 5;
    localparam int NUM_IN_SEL = 10;
    localparam int NUM_OUT_SEL = 3;
    localparam int NUM_PINS = 32;

    // Register offsets
    localparam logic [11:0] OFS_PIN0_FUNC = 12'hec6;
    localparam logic [11:0] OFS_PIN1_FUNC = 12'hec7;
    localparam logic [11:0] OFS_PIN2_FUNC = 12'hec8;
    localparam logic [11:0] OFS_CAPTURE1 = 12'heed;
    localparam logic [11:0] OFS_CAPTURE2 = 12'heee;
    localparam logic [11:0] OFS_TIMER1_GATE = 12'hef2;
    localparam logic [11:0] OFS_TIMER3_GATE = 12'hef3;
    localparam logic [11:0] OFS_SERIAL2_RX = 12'hef6;
    localparam logic [11:0] OFS_SERIAL2_CLK = 12'hef7;
    localparam logic [11:0] OFS_SPI2_DIN = 12'hefb;
    localparam logic [11:0] OFS_SPI2_CLK = 12'hefc;
    localparam logic [11:0] OFS_SPI2_SEL = 12'hefd;
    localparam logic [11:0] OFS_PWM_FAULT = 12'hefe;
    localparam logic [11:0] OFS_LOCK_CTRL = 12'heff;

    // Reset values and field positions
    localparam logic [4:0] IN_SEL_RESET = 5'h1f;
    localparam logic [4:0] OUT_SEL_RESET = 5'h00;
    localparam int LOCK_BIT = 0;

    // Index order of input-select fields
    localparam int IDX_CAPTURE_A = 0;
    localparam int IDX_CAPTURE_B = 1;
    localparam int IDX_TIMER_A_GATE = 2;
    localparam int IDX_TIMER_C_GATE = 3;
    localparam int IDX_SERIAL_B_RX = 4;
    localparam int IDX_SERIAL_B_CLK = 5;
    localparam int IDX_SPI_B_DIN = 6;
    localparam int IDX_SPI_B_CLK = 7;
    localparam int IDX_SPI_B_SEL = 8;
    localparam int IDX_PWM_FAULT = 9;

    // Register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Routed peripheral inputs
    typedef struct packed {
        logic capture_a;
        logic capture_b;
        logic timer_a_gate;
        logic timer_c_gate;
        logic serial_b_receive;
        logic serial_b_clock;
        logic spi_b_data_in;
        logic spi_b_clock;
        logic spi_b_select_input;
        logic pwm_fault_input;
    } periph_in_t;

endpackage : pin_select_pkg

// file: core/pin_level_sync.sv
// Purpose: Two-flop synchroniser for a bus of pin levels.
// Assumes: Pins are asynchronous to clk.
// Notes: Both stages reset to zero, so idle-high lines read low until two clocks after reset.
module pin_level_sync #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : pin_level_sync

// file: core/remappable_pin_select_regs.sv
// Purpose: Register file and routing for remappable pin selection.
// Assumes: One 100 MHz clock, plain register port, reads answer next cycle.
// Notes: Lock control register sits at its own offset beside the selects.
//
// Design decision made here: the strobed register port.
import pin_select_pkg::*;

// Overview of operation
// [R1] Select writes are ignored while the lock bit is set.
// [R2] Bits 7 to 5 of every select register ignore writes, read zero.
// [R3] Input-select fields are 5 bits and reset to all ones.
// [R4] Two fields pick the pins for capture channels one and two.
// [R5] Two fields pick the pins for timer one and timer three gates.
// [R6] Two fields route pins to second serial port receive and clock.
// [R7] Three fields route pins to second SPI data, clock and select.
// [R8] One field picks the pin driving the PWM fault input.
// [R9] Pins 0 to 2 each pick an output function; fields reset to zero.
// [R10] Every reset clears the lock bit.
// [R11] With the one-way option set, software cannot clear a set lock.
// [R12] Software writes the two-byte key sequence before changing the lock; the block does not check it.
// [R13] Each peripheral input is muxed from pins by its stored number.
module remappable_pin_select_regs #(
    parameter int NUM_FUNCS = 32
) (
    input wire logic clk,
    input wire logic rst,
    input pin_select_pkg::reg_req_t req,
    output logic [pin_select_pkg::DATA_W-1:0] rdata,
    input wire logic one_way_lock_option,
    input wire logic [pin_select_pkg::NUM_PINS-1:0] remappable_pin,
    input wire logic [NUM_FUNCS-1:0] periph_out_func,
    output pin_select_pkg::periph_in_t periph_in,
    output logic [pin_select_pkg::NUM_OUT_SEL-1:0] pin_out,
    output logic [pin_select_pkg::NUM_OUT_SEL-1:0][4:0] pin_func_sel,
    output logic pin_config_lock
);
    import pin_select_pkg::*;

    logic [NUM_IN_SEL-1:0][SEL_W-1:0] in_sel_q;
    logic [NUM_OUT_SEL-1:0][SEL_W-1:0] out_sel_q;
    logic lock_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic [NUM_PINS-1:0] pin_sync;
    logic [NUM_IN_SEL-1:0] routed_d;
    logic [NUM_IN_SEL-1:0] routed_q;
    logic [NUM_OUT_SEL-1:0] pin_out_q;
    logic [NUM_IN_SEL-1:0] in_hit;
    logic [NUM_OUT_SEL-1:0] out_hit;
    logic [NUM_IN_SEL-1:0][ADDR_W-1:0] in_ofs;
    logic [NUM_OUT_SEL-1:0][ADDR_W-1:0] out_ofs;
    logic lock_hit;
    logic sel_wr_ok;
    logic lock_d;

    // Offset table in the same index order as the input fields
    assign in_ofs[IDX_CAPTURE_A] = OFS_CAPTURE1;
    assign in_ofs[IDX_CAPTURE_B] = OFS_CAPTURE2;
    assign in_ofs[IDX_TIMER_A_GATE] = OFS_TIMER1_GATE;
    assign in_ofs[IDX_TIMER_C_GATE] = OFS_TIMER3_GATE;
    assign in_ofs[IDX_SERIAL_B_RX] = OFS_SERIAL2_RX;
    assign in_ofs[IDX_SERIAL_B_CLK] = OFS_SERIAL2_CLK;
    assign in_ofs[IDX_SPI_B_DIN] = OFS_SPI2_DIN;
    assign in_ofs[IDX_SPI_B_CLK] = OFS_SPI2_CLK;
    assign in_ofs[IDX_SPI_B_SEL] = OFS_SPI2_SEL;
    assign in_ofs[IDX_PWM_FAULT] = OFS_PWM_FAULT;
    assign out_ofs[0] = OFS_PIN0_FUNC;
    assign out_ofs[1] = OFS_PIN1_FUNC;
    assign out_ofs[2] = OFS_PIN2_FUNC;

    // Address decode
    assign lock_hit = (req.addr == OFS_LOCK_CTRL);
    assign sel_wr_ok = req.wr && !lock_q; // R1

    // Pins are asynchronous, so they pass two flops before the muxes
    pin_level_sync #(
        .WIDTH(NUM_PINS)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .async_in(remappable_pin),
        .sync_out(pin_sync)
    );

    // Per-field decode, storage and routing
    for (genvar i = 0; i < NUM_IN_SEL; i++) begin : g_in
        assign in_hit[i] = (req.addr == in_ofs[i]);
        assign routed_d[i] = pin_sync[in_sel_q[i]]; // R13

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                in_sel_q[i] <= IN_SEL_RESET; // R3
            end else if (sel_wr_ok && in_hit[i]) begin
                in_sel_q[i] <= req.wdata[SEL_W-1:0]; // R2 R3
            end
        end
    end

    for (genvar j = 0; j < NUM_OUT_SEL; j++) begin : g_out
        logic [NUM_FUNCS-1:0] func_vec;
        assign out_hit[j] = (req.addr == out_ofs[j]);
        assign func_vec = periph_out_func;

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                out_sel_q[j] <= OUT_SEL_RESET; // R9
            end else if (sel_wr_ok && out_hit[j]) begin
                out_sel_q[j] <= req.wdata[SEL_W-1:0]; // R9 R2
            end
        end

        // Function numbers past the table drive the pin low
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                pin_out_q[j] <= 1'b0;
            end else begin
                pin_out_q[j] <= (int'(out_sel_q[j]) < NUM_FUNCS) ?
                    func_vec[out_sel_q[j]] : 1'b0; // R9
            end
        end
    end

    // Lock: a set lock stays set under the one-way option until reset
    always_comb begin
        lock_d = lock_q;
        if (req.wr && lock_hit) begin
            if (req.wdata[LOCK_BIT]) begin
                lock_d = 1'b1;
            end else if (!one_way_lock_option) begin // R11
                lock_d = 1'b0;
            end
        end
    end

    // No key sequence is checked; a write to the lock offset updates the lock, except a clear that the one-way option blocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_q <= 1'b0; // R10
        end else begin
            lock_q <= lock_d;
        end
    end

    // Read mux; bits above the field read as zero, unmapped reads zero
    always_comb begin
        rdata_d = '0;
        for (int k = 0; k < NUM_IN_SEL; k++) begin
            if (in_hit[k]) begin
                rdata_d = {3'h0, in_sel_q[k]}; // R2
            end
        end
        for (int k = 0; k < NUM_OUT_SEL; k++) begin
            if (out_hit[k]) begin
                rdata_d = {3'h0, out_sel_q[k]}; // R2
            end
        end
        if (lock_hit) begin
            rdata_d = {7'h00, lock_q};
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (req.rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    // Routed inputs registered so peripherals see clean levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            routed_q <= '0;
        end else begin
            routed_q <= routed_d; // R13
        end
    end

    assign rdata = rdata_q;
    assign pin_config_lock = lock_q;
    assign pin_out = pin_out_q;
    assign pin_func_sel = out_sel_q;

    // Field to peripheral mapping
    assign periph_in.capture_a = routed_q[IDX_CAPTURE_A]; // R4
    assign periph_in.capture_b = routed_q[IDX_CAPTURE_B]; // R4
    assign periph_in.timer_a_gate = routed_q[IDX_TIMER_A_GATE]; // R5
    assign periph_in.timer_c_gate = routed_q[IDX_TIMER_C_GATE]; // R5
    assign periph_in.serial_b_receive = routed_q[IDX_SERIAL_B_RX]; // R6
    assign periph_in.serial_b_clock = routed_q[IDX_SERIAL_B_CLK]; // R6
    assign periph_in.spi_b_data_in = routed_q[IDX_SPI_B_DIN]; // R7
    assign periph_in.spi_b_clock = routed_q[IDX_SPI_B_CLK]; // R7
    assign periph_in.spi_b_select_input = routed_q[IDX_SPI_B_SEL]; // R7
    assign periph_in.pwm_fault_input = routed_q[IDX_PWM_FAULT]; // R8

endmodule : remappable_pin_select_regs

// file: bench/pin_select_props.sv
// Purpose: Port properties of the pin-select registers.
// Assumes: One clock, async active-high reset.
// Notes: Bound to the block below.
module pin_select_props #(
    parameter int NUM_FUNCS = 32
) (
    input wire logic clk,
    input wire logic rst,
    input pin_select_pkg::reg_req_t req,
    input logic [7:0] rdata,
    input wire logic one_way_lock_option,
    input wire logic [31:0] remappable_pin,
    input wire logic [NUM_FUNCS-1:0] periph_out_func,
    input pin_select_pkg::periph_in_t periph_in,
    input logic [2:0] pin_out,
    input logic [2:0][4:0] pin_func_sel,
    input logic pin_config_lock
);
    import pin_select_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Register port, lock and output routing
    AST_HIGH_ZERO: assert property (rdata[7:5] == 3'h0)
        else $error("upper bits set");
    AST_LOCKED: assert property (pin_config_lock && req.wr |=> $stable(pin_func_sel))
        else $error("locked select changed");
    AST_LOCK_SET: assert property (req.wr && req.addr == OFS_LOCK_CTRL && req.wdata[0]
        |=> pin_config_lock) else $error("lock not set");
    AST_ONE_WAY: assert property (one_way_lock_option && pin_config_lock |=> pin_config_lock)
        else $error("lock cleared");
    AST_FUNC_WR: assert property (!pin_config_lock && req.wr && req.addr == OFS_PIN0_FUNC
        |=> pin_func_sel[0] == $past(req.wdata[4:0])) else $error("select not written");
    AST_FUNC_RD: assert property (req.rd && req.addr == OFS_PIN1_FUNC
        |=> rdata == {3'h0, $past(pin_func_sel[1])}) else $error("bad readback");
    AST_PIN_OUT: assert property (1'b1
        |=> pin_out[2] == $past(periph_out_func[pin_func_sel[2]])) else $error("bad pin out");
    AST_LOCK_RST: assert property ($past(rst) |-> !pin_config_lock)
        else $error("lock survived reset");
endmodule : pin_select_props
bind remappable_pin_select_regs pin_select_props #(.NUM_FUNCS(NUM_FUNCS)) props (.clk, .rst,
    .req, .rdata, .one_way_lock_option, .remappable_pin, .periph_out_func, .periph_in,
    .pin_out, .pin_func_sel, .pin_config_lock);

// file: bench/pin_partner.sv
// Purpose: Pins and peripheral outputs facing the pin-select block.
// Assumes: Pin levels move at any time relative to clk.
// Notes: Bench sets the levels; pins land 3 ns late.
module pin_partner (
    input wire logic [31:0] pin_set,
    input wire logic [31:0] func_set,
    output wire logic [31:0] remappable_pin,
    output wire logic [31:0] periph_out_func
);
    timeunit 1ns;
    timeprecision 1ps;
    // Off-edge skew so the synchroniser really sees async pins
    assign #3 remappable_pin = pin_set;
    // Peripheral outputs already live in the clock domain
    assign periph_out_func = func_set;
endmodule : pin_partner

// file: bench/remappable_pin_select_regs_tb_top.sv
// Purpose: Self-checking bench for the pin-select registers.
// Assumes: Read data arrive one cycle after the strobe.
// Notes: Key bytes go to an address the block ignores.
module remappable_pin_select_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pin_select_pkg::*;
    localparam logic [11:0] KEY_ADDR = 12'he00; // Key register lives elsewhere
    logic clk = 1'b0, rst = 1'b1, one_way_lock_option = 1'b0, rd_seen = 1'b0, lock_m = 1'b0;
    logic [31:0] pin_set = '0, func_set = '0, remappable_pin, periph_out_func, seed = 32'hb7fe2029;
    logic [7:0] rdata, exp_q[$];
    logic [4:0] mem[13];
    logic [2:0][4:0] pin_func_sel;
    logic [2:0] pin_out;
    logic pin_config_lock;
    reg_req_t req = '0;
    periph_in_t periph_in;
    int n_errors = 0, comparisons = 0, cycles = 0;
    logic [11:0] sel_addr[13] = '{OFS_CAPTURE1, OFS_CAPTURE2, OFS_TIMER1_GATE, OFS_TIMER3_GATE,
        OFS_SERIAL2_RX, OFS_SERIAL2_CLK, OFS_SPI2_DIN, OFS_SPI2_CLK, OFS_SPI2_SEL,
        OFS_PWM_FAULT, OFS_PIN0_FUNC, OFS_PIN1_FUNC, OFS_PIN2_FUNC};
    always #5 clk = ~clk;
    remappable_pin_select_regs uut (.clk, .rst, .req, .rdata, .one_way_lock_option,
        .remappable_pin, .periph_out_func, .periph_in, .pin_out, .pin_func_sel, .pin_config_lock);
    pin_partner partner (.pin_set, .func_set, .remappable_pin, .periph_out_func);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // One bus cycle; strobes stay until the next call replaces them
    task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: w, rd: r};
    endtask : op
    task automatic idle(input int n);
        repeat (n) op(1'b0, 1'b0, 12'h0, 8'h0);
    endtask : idle
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        op(1'b0, 1'b1, a, 8'h0);
    endtask : rd
    // The model only follows writes that the lock lets through
    task automatic wr(input int k, input logic [7:0] d);
        op(1'b1, 1'b0, sel_addr[k], d);
        if (!lock_m)
            mem[k] = d[4:0];
    endtask : wr
    task automatic set_lock(input logic v);
        op(1'b1, 1'b0, KEY_ADDR, 8'h55);
        op(1'b1, 1'b0, KEY_ADDR, 8'haa);
        op(1'b1, 1'b0, OFS_LOCK_CTRL, {7'h0, v});
        if (!(lock_m && one_way_lock_option))
            lock_m = v;
        rd(OFS_LOCK_CTRL, {7'h0, lock_m});
    endtask : set_lock
    task automatic chk_all;
        for (int i = 0; i < 13; i++)
            rd(sel_addr[i], {3'h0, mem[i]});
    endtask : chk_all
    task automatic reset_model;
        for (int i = 0; i < 13; i++)
            mem[i] = (i < 10) ? IN_SEL_RESET : OUT_SEL_RESET;
        lock_m = 1'b0;
    endtask : reset_model
    task automatic finish_test;
        if (n_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    // Read data belong to the oldest pending note
    always @(posedge clk) begin
        if (rd_seen)
            chk(rdata, exp_q.pop_front());
        rd_seen <= req.rd;
    end
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        logic [31:0] v;
        logic [4:0] p;
        reset_model();
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Reset values, then random full bytes whose upper bits must read zero, plus an unmapped read
        chk_all();
        for (int i = 0; i < 13; i++) begin
            v = xs();
            wr(i, v[7:0]);
            rd(sel_addr[i], {3'h0, v[4:0]});
        end
        rd(KEY_ADDR, 8'h00);
        // Each input select routes its pin, both levels
        for (int i = 0; i < 10; i++) begin
            v = xs();
            p = v[12:8];
            wr(i, {3'h0, p});
            pin_set <= v;
            idle(5);
            chk({7'h0, periph_in[9 - i]}, {7'h0, v[p]});
            pin_set <= ~v;
            idle(5);
            chk({7'h0, periph_in[9 - i]}, {7'h0, ~v[p]});
        end
        // Output selects pick one function per pin
        for (int i = 0; i < 3; i++) begin
            v = xs();
            p = v[4:0];
            wr(10 + i, {3'h0, p});
            func_set <= xs();
            idle(3);
            chk({7'h0, pin_out[i]}, {7'h0, func_set[p]});
        end
        // Lock freezes selects; clearing works only without one-way option
        set_lock(1'b1);
        wr(0, 8'h07);
        wr(12, 8'h04);
        chk_all();
        set_lock(1'b0);
        wr(1, 8'h0a);
        chk_all();
        one_way_lock_option <= 1'b1;
        set_lock(1'b1);
        set_lock(1'b0);
        wr(11, 8'h13);
        chk_all();
        // Reset in mid-run clears the lock and restores selects
        idle(2);
        rst <= 1'b1;
        idle(3);
        rst <= 1'b0;
        reset_model();
        rd(OFS_LOCK_CTRL, 8'h00);
        wr(2, 8'h11);
        chk_all();
        idle(2);
        finish_test();
    end
endmodule : remappable_pin_select_regs_tb_top
